//--- pkg/psw_pkg.sv
// package of constants and types for the processor supervisor with reset watchdog
//==============================================================
package psw_pkg;
    //==============================================================
    // timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned HOLD_MS = 250;
    localparam int unsigned DEBOUNCE_MS = 4;
    localparam int unsigned WD_SHORT_MS = 150;
    localparam int unsigned WD_MID_MS = 600;
    localparam int unsigned WD_LONG_MS = 1200;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned WD_SHORT_CYC = WD_SHORT_MS * CYC_PER_MS;
    localparam int unsigned WD_MID_CYC = WD_MID_MS * CYC_PER_MS;
    localparam int unsigned WD_LONG_CYC = WD_LONG_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 32;
    //==============================================================
    // selector encodings
    localparam logic [1:0] TD_LOW = 2'h0;
    localparam logic [1:0] TD_OPEN = 2'h1;
    localparam logic [1:0] TD_HIGH = 2'h2;

    typedef struct packed {
        logic supply_low;
        logic button;
        logic watchdog;
    } psw_cause_s;

    typedef enum logic [1:0] {PSW_HOLD, PSW_RUN} psw_state_e;
endpackage : psw_pkg

//--- core/psw_filter.sv
// synchroniser and debounce filter for one pin input
`timescale 1ns/1ps
module psw_filter
    import psw_pkg::*;
#(
    parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    input wire logic init_i,
    output logic sync_o,
    output logic level_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic [CNT_W-1:0] cnt_ff;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // level changes only after input stays at the new value for STABLE_CYC
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            level_ff <= init_i;
            cnt_ff <= '0;
        end else if (s2_ff != s3_ff || s3_ff == level_ff) begin
            cnt_ff <= '0;
        end else if (cnt_ff >= CNT_W'(STABLE_CYC - 1)) begin
            level_ff <= s3_ff;
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign sync_o = (s2_ff == s3_ff) ? s3_ff : level_ff;
    assign level_o = level_ff;
endmodule : psw_filter

//--- core/psw_supervisor.sv
// supervisor top: reset cause combination, hold timer and watchdog
`timescale 1ns/1ps
module psw_supervisor
    import psw_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HOLD_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter int unsigned WD_MID_CYCLES = WD_MID_CYC,
    parameter int unsigned WD_LONG_CYCLES = WD_LONG_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic SUPPLY_BELOW_475_I,
    input wire logic SUPPLY_BELOW_450_I,
    input wire logic THRESHOLD_SELECT_I,
    input wire logic [1:0] TIMEOUT_SELECT_I,
    input wire logic MANUAL_RESET_BUTTON_N_I,
    input wire logic WATCHDOG_KICK_N_I,
    output logic RESET_O,
    output logic RESET_N_O,
    output logic RESET_N_OE_N_O
);
    //==============================================================
    // input conditioning
    logic btn_level;
    logic kick_sync;
    logic kick_prev_ff;
    logic sup475_s1_ff, sup475_s2_ff, sup475_s3_ff;
    logic sup450_s1_ff, sup450_s2_ff, sup450_s3_ff;
    logic sup475_ff, sup450_ff;

    psw_filter #(.STABLE_CYC(DEBOUNCE_CYCLES)) u_button (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pin_i(MANUAL_RESET_BUTTON_N_I),
        .init_i(1'b1),
        .sync_o(),
        .level_o(btn_level)
    );

    // kick uses sync only, no debounce, so short strobes still count
    psw_filter #(.STABLE_CYC(1)) u_kick (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pin_i(WATCHDOG_KICK_N_I),
        .init_i(1'b1),
        .sync_o(kick_sync),
        .level_o()
    );

    // supply comparator flags; reset state assumes supply low until seen good
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            sup475_s1_ff <= 1'b1;
            sup475_s2_ff <= 1'b1;
            sup475_s3_ff <= 1'b1;
            sup450_s1_ff <= 1'b1;
            sup450_s2_ff <= 1'b1;
            sup450_s3_ff <= 1'b1;
            sup475_ff <= 1'b1;
            sup450_ff <= 1'b1;
        end else begin
            sup475_s1_ff <= SUPPLY_BELOW_475_I;
            sup475_s2_ff <= sup475_s1_ff;
            sup475_s3_ff <= sup475_s2_ff;
            sup450_s1_ff <= SUPPLY_BELOW_450_I;
            sup450_s2_ff <= sup450_s1_ff;
            sup450_s3_ff <= sup450_s2_ff;
            if (sup475_s2_ff == sup475_s3_ff) begin
                sup475_ff <= sup475_s3_ff;
            end
            if (sup450_s2_ff == sup450_s3_ff) begin
                sup450_ff <= sup450_s3_ff;
            end
        end
    end

    // strap pins are asynchronous too, so they share the three-stage scheme
    logic sel_s1_ff;
    logic sel_s2_ff;
    logic sel_s3_ff;
    logic sel_ff;
    logic [1:0] tsel_s1_ff;
    logic [1:0] tsel_s2_ff;
    logic [1:0] tsel_s3_ff;
    logic [1:0] tsel_ff;
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            sel_s1_ff <= 1'b0;
            sel_s2_ff <= 1'b0;
            sel_s3_ff <= 1'b0;
            sel_ff <= 1'b0;
            tsel_s1_ff <= TD_OPEN;
            tsel_s2_ff <= TD_OPEN;
            tsel_s3_ff <= TD_OPEN;
            tsel_ff <= TD_OPEN;
        end else begin
            sel_s1_ff <= THRESHOLD_SELECT_I;
            sel_s2_ff <= sel_s1_ff;
            sel_s3_ff <= sel_s2_ff;
            tsel_s1_ff <= TIMEOUT_SELECT_I;
            tsel_s2_ff <= tsel_s1_ff;
            tsel_s3_ff <= tsel_s2_ff;
            if (sel_s2_ff == sel_s3_ff) begin
                sel_ff <= sel_s3_ff;
            end
            if (tsel_s2_ff == tsel_s3_ff) begin
                tsel_ff <= tsel_s3_ff;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            kick_prev_ff <= 1'b1;
        end else begin
            kick_prev_ff <= kick_sync;
        end
    end

    //==============================================================
    // cause combination
    function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
        case (sel)
            TD_LOW: wd_limit = CNT_W'(WD_SHORT_CYCLES);
            TD_OPEN: wd_limit = CNT_W'(WD_MID_CYCLES);
            TD_HIGH: wd_limit = CNT_W'(WD_LONG_CYCLES);
            default: wd_limit = CNT_W'(WD_MID_CYCLES);
        endcase
    endfunction : wd_limit

    psw_cause_s cause;
    logic wd_expired;
    logic kick_fall;
    psw_state_e state_ff;
    logic [CNT_W-1:0] hold_cnt_ff;
    logic [CNT_W-1:0] wd_cnt_ff;
    logic any_cause;

    assign kick_fall = kick_prev_ff & ~kick_sync;
    always_comb begin
        cause.supply_low = sel_ff ? sup450_ff : sup475_ff;
        cause.button = ~btn_level;
        cause.watchdog = wd_expired;
    end
    assign any_cause = cause.supply_low | cause.button | cause.watchdog;

    //==============================================================
    // hold timer: power-up starts in hold
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            state_ff <= PSW_HOLD;
            hold_cnt_ff <= '0;
        end else begin
            case (state_ff)
                PSW_HOLD: begin
                    if (any_cause) begin
                        hold_cnt_ff <= '0;
                    end else if (hold_cnt_ff >= CNT_W'(HOLD_CYCLES - 1)) begin
                        hold_cnt_ff <= '0;
                        state_ff <= PSW_RUN;
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff + 1'b1;
                    end
                end
                PSW_RUN: begin
                    if (any_cause) begin
                        state_ff <= PSW_HOLD;
                    end
                end
                default: state_ff <= PSW_HOLD;
            endcase
        end
    end

    //==============================================================
    // watchdog: counts only in run, cleared while in hold
    assign wd_expired = (state_ff == PSW_RUN) && (wd_cnt_ff >= wd_limit(tsel_ff) - 1'b1);
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            wd_cnt_ff <= '0;
        end else if (state_ff != PSW_RUN || kick_fall) begin
            wd_cnt_ff <= '0;
        end else begin
            wd_cnt_ff <= wd_cnt_ff + 1'b1;
        end
    end

    //==============================================================
    // outputs: RESET_O and RESET_N_OE_N_O both from one flip-flop so they never disagree; RESET_N_O is tied low
    logic rst_ff;
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            rst_ff <= 1'b1;
        end else begin
            rst_ff <= (state_ff == PSW_HOLD) || any_cause;
        end
    end
    assign RESET_O = rst_ff;
    assign RESET_N_O = 1'b0;
    assign RESET_N_OE_N_O = ~rst_ff;
endmodule : psw_supervisor

//--- testbench/psw_monitor.sv
// port checker for the supervisor, with its bind
`timescale 1ns/1ps
module psw_monitor #(
    parameter int unsigned HOLD_CYCLES = 50,
    parameter int unsigned DEBOUNCE_CYCLES = 8,
    parameter int unsigned WD_SHORT_CYCLES = 100,
    parameter int unsigned WD_MID_CYCLES = 200,
    parameter int unsigned WD_LONG_CYCLES = 400
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic SUPPLY_BELOW_475_I,
    input wire logic SUPPLY_BELOW_450_I,
    input wire logic THRESHOLD_SELECT_I,
    input wire logic [1:0] TIMEOUT_SELECT_I,
    input wire logic MANUAL_RESET_BUTTON_N_I,
    input wire logic WATCHDOG_KICK_N_I,
    input wire logic RESET_O,
    input wire logic RESET_N_OE_N_O
);
    //====
    // helper counters
    logic sel;
    logic kick_ff;
    int unsigned lim;
    int unsigned btn_ff;
    int unsigned hi_ff;
    int unsigned wd_ff;
    assign sel = THRESHOLD_SELECT_I ? SUPPLY_BELOW_450_I : SUPPLY_BELOW_475_I;
    assign lim = (TIMEOUT_SELECT_I == 2'h0) ? WD_SHORT_CYCLES :
        (TIMEOUT_SELECT_I == 2'h2) ? WD_LONG_CYCLES : WD_MID_CYCLES;
    // hold count restarts on any cause, so it measures quiet time only
    always_ff @(posedge SYS_CLK_I) begin
        kick_ff <= WATCHDOG_KICK_N_I;
        btn_ff <= (!NRST_I || MANUAL_RESET_BUTTON_N_I) ? '0 : btn_ff + 1'h1;
        hi_ff <= (!NRST_I || !RESET_O || sel || !MANUAL_RESET_BUTTON_N_I) ? '0 : hi_ff + 1'h1;
        wd_ff <= (!NRST_I || RESET_O || (kick_ff && !WATCHDOG_KICK_N_I)) ? '0 : wd_ff + 1'h1;
    end
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    property p_agree; RESET_N_OE_N_O == !RESET_O; endproperty
    a_agree: assert property (p_agree) else $error("outputs disagree");
    property p_pwr; $rose(NRST_I) |-> RESET_O; endproperty
    a_pwr: assert property (p_pwr) else $error("no power-up reset");
    property p_sup; sel [*7] |-> RESET_O; endproperty
    a_sup: assert property (p_sup) else $error("supply low ignored");
    property p_btn; btn_ff >= DEBOUNCE_CYCLES + 6 |-> RESET_O; endproperty
    a_btn: assert property (p_btn) else $error("button ignored");
    property p_min; $fell(RESET_O) |-> hi_ff >= HOLD_CYCLES - 1; endproperty
    a_min: assert property (p_min) else $error("hold too short");
    property p_max; hi_ff <= HOLD_CYCLES + DEBOUNCE_CYCLES + 8; endproperty
    a_max: assert property (p_max) else $error("hold too long");
    property p_late; wd_ff <= lim + 6; endproperty
    a_late: assert property (p_late) else $error("watchdog late");
    property p_early; $rose(RESET_O) && !sel && btn_ff == 0 |-> wd_ff >= lim - 3; endproperty
    a_early: assert property (p_early) else $error("watchdog early");
endmodule : psw_monitor

bind psw_supervisor psw_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .WD_SHORT_CYCLES(WD_SHORT_CYCLES), .WD_MID_CYCLES(WD_MID_CYCLES), .WD_LONG_CYCLES(WD_LONG_CYCLES))
    psw_monitor_inst (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .SUPPLY_BELOW_475_I(SUPPLY_BELOW_475_I),
    .SUPPLY_BELOW_450_I(SUPPLY_BELOW_450_I), .THRESHOLD_SELECT_I(THRESHOLD_SELECT_I),
    .TIMEOUT_SELECT_I(TIMEOUT_SELECT_I), .MANUAL_RESET_BUTTON_N_I(MANUAL_RESET_BUTTON_N_I),
    .WATCHDOG_KICK_N_I(WATCHDOG_KICK_N_I), .RESET_O(RESET_O), .RESET_N_OE_N_O(RESET_N_OE_N_O));

//--- testbench/psw_host_model.sv
// model of the supervised processor and its push-button
`timescale 1ns/1ps
module psw_host_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic kick_en_i,
    input wire logic [15:0] gap_i,
    output logic kick_n_o,
    output logic button_n_o
);
    int cnt = 0;
    initial button_n_o = 1'h1;
    // a processor held in reset cannot kick
    // a strobe is three cycles low, since the input filter drops single-cycle pulses;
    // a strobe once begun is finished, so disabling kicks never leaves a cut pulse
    always @(posedge clk_i) begin
        #5;
        cnt = (reset_i || cnt >= gap_i || (cnt == 0 && !kick_en_i)) ? 0 : cnt + 1;
        kick_n_o = !(cnt >= 1 && cnt <= 3);
    end
    task automatic press(input int len);
        button_n_o = 1'h0;
        repeat (len) @(posedge clk_i);
        #5 button_n_o = 1'h1;
    endtask : press
endmodule : psw_host_model

//--- testbench/psw_supervisor_tb.sv
// self-checking bench for the supervisor
`timescale 1ns/1ps
module psw_supervisor_tb;
    import psw_pkg::*;
    localparam int HC = 50;
    localparam int DC = 8;
    logic sys_clk = 0, nrst = 0, s475 = 0, s450 = 0, thr = 0, k_en = 0, rst, rst_n, oe_n, kick_n, pb_n;
    logic [1:0] tsel = 2'h0;
    int bad_count = 0, num_checks = 0, gap = 20;
    initial forever #25 sys_clk = !sys_clk;
    psw_supervisor #(.HOLD_CYCLES(HC), .DEBOUNCE_CYCLES(DC), .WD_SHORT_CYCLES(100), .WD_MID_CYCLES(200),
        .WD_LONG_CYCLES(400)) psw_supervisor_inst (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .SUPPLY_BELOW_475_I(s475),
        .SUPPLY_BELOW_450_I(s450), .THRESHOLD_SELECT_I(thr), .TIMEOUT_SELECT_I(tsel),
        .MANUAL_RESET_BUTTON_N_I(pb_n), .WATCHDOG_KICK_N_I(kick_n), .RESET_O(rst), .RESET_N_O(rst_n),
        .RESET_N_OE_N_O(oe_n));
    psw_host_model psw_host_model_inst (.clk_i(sys_clk), .reset_i(rst), .kick_en_i(k_en), .gap_i(gap[15:0]),
        .kick_n_o(kick_n), .button_n_o(pb_n));
    //====
    // helpers
    task automatic chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t output %b expected %b", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : step
    task automatic wait_rst(input logic v, input int lim);
        for (int i = 0; i < lim && rst !== v; i++) step(1);
        chk(rst, v);
        if (rst !== v) give_verdict();
    endtask : wait_rst
    function automatic int wd_lim(input logic [1:0] s);
        return (s == 2'h0) ? 100 : (s == 2'h2) ? 400 : 200;
    endfunction : wd_lim
    initial begin
        void'($urandom(32'h53ad_e7fe));
        step(8);
        nrst = 1;
        step(HC - 4);
        chk(rst, 1'h1);
        wait_rst(1'h0, 20);
        chk(rst_n, 1'h0);
        chk(oe_n, 1'h1);
        for (int t = 0; t < 4; t++) begin
            tsel = t[1:0];
            gap = $urandom_range(wd_lim(tsel) - 20, 10);
            k_en = 1;
            step(3 * wd_lim(tsel));
            chk(rst, 1'h0);
            k_en = 0;
            wait_rst(1'h1, wd_lim(tsel) + 10);
            wait_rst(1'h0, HC + 10);
            step(wd_lim(tsel) - 6);
            chk(rst, 1'h0);
            wait_rst(1'h1, 12);
            chk(oe_n, 1'h0);
            wait_rst(1'h0, HC + 10);
        end
        k_en = 1;
        repeat (4) begin
            psw_host_model_inst.press($urandom_range(DC - 3, 1));
            step(2 * DC);
            chk(rst, 1'h0);
        end
        psw_host_model_inst.press(DC + 8);
        chk(rst, 1'h1);
        step(HC);
        chk(rst, 1'h1);
        wait_rst(1'h0, DC + 20);
        for (int t = 0; t < 2; t++) begin
            nrst = 0;
            thr = t[0];
            step(2);
            nrst = 1;
            wait_rst(1'h0, HC + 20);
            s475 = thr;
            s450 = !thr;
            step(10);
            chk(rst, 1'h0);
            s475 = 1;
            s450 = 1;
            wait_rst(1'h1, 8);
            step(HC);
            s475 = 0;
            s450 = 0;
            step(HC - 2);
            chk(rst, 1'h1);
            wait_rst(1'h0, 20);
        end
        give_verdict();
    end
endmodule : psw_supervisor_tb
